// ---- common/gpm_pkg.sv ----
// package of pin classes, mode encodings and carrier structs for the pin mode block
// Functional notes
// [R1] standard pin: ddr/opt select float, pull-up, od, pp
// [R2] pull-up interrupt pin: opt=1 input adds interrupt
// [R3] no-pull interrupt pin: interrupt input stays floating
// [R4] true open drain: ddr only, never drives high
// [R5] software sets pull-up interrupt before halt
// [R6] software rewrites interrupt sensitivity before halt
// [R7] input-only pull-up pin always pulls up; reset clears o_pull_en until the first clock edge after release
package gpm_pkg;

  // ****************************************
  // pin classes and geometry
  // ****************************************
  localparam int GPM_PINS = 8;
  localparam logic [2:0] GPM_CLASS_STD = 3'h0;
  localparam logic [2:0] GPM_CLASS_INT_PU = 3'h1;
  localparam logic [2:0] GPM_CLASS_INT_NOPU = 3'h2;
  localparam logic [2:0] GPM_CLASS_TRUE_OD = 3'h3;
  localparam logic [2:0] GPM_CLASS_PU_ONLY = 3'h4;

  // ****************************************
  // reset values of the configuration
  // ****************************************
  localparam logic GPM_DDR_RST = 1'b0;
  localparam logic GPM_OPT_RST = 1'b0;

  // resulting pin mode, one-hot
  typedef enum logic [4:0] {
    GPM_FLOAT_IN = 5'h01,
    GPM_PULLUP_IN = 5'h02,
    GPM_OPEN_DRAIN = 5'h04,
    GPM_PUSH_PULL = 5'h08,
    GPM_TRUE_OD = 5'h10
  } gpm_mode_t;

  // per-pin configuration from software
  typedef struct packed {
    logic ddr;
    logic opt;
    logic data;
  } gpm_cfg_t;

  // per-pin drive toward the pad
  typedef struct packed {
    logic out;
    logic oe;
    logic pull_en;
    logic irq_en;
  } gpm_drv_t;

endpackage

// ---- design/gpm_pin_cell.sv ----
// one pin: mode decode, pad drive and input synchroniser
`timescale 1ns/1ps
module gpm_pin_cell #(
  parameter logic [2:0] PIN_CLASS = 3'h0
) (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  // configuration
  input wire gpm_pkg::gpm_cfg_t i_cfg,
  // pad
  input wire logic i_pad_in,
  output logic o_pad_out,
  output logic o_pad_oe,
  output logic o_pull_en,
  // core side
  output logic o_irq_in,
  output logic o_irq_en,
  output logic o_in_sync,
  output gpm_pkg::gpm_mode_t o_mode
);
  import gpm_pkg::*;

  gpm_mode_t mode_d;
  gpm_mode_t mode_q;
  gpm_drv_t drv_d;
  gpm_drv_t drv_q;
  logic sync1_q;
  logic sync2_q;
  logic sync_d;

  // mode decode per pin class
  always_comb begin
    mode_d = GPM_FLOAT_IN;
    drv_d = '0;
    case (PIN_CLASS)
      GPM_CLASS_TRUE_OD: begin
        // option bit has no effect here
        mode_d = i_cfg.ddr ? GPM_TRUE_OD : GPM_FLOAT_IN; // R4
        drv_d.oe = i_cfg.ddr & ~i_cfg.data; // R4
      end
      GPM_CLASS_PU_ONLY: begin
        // config bits ignored: always pull-up input
        mode_d = GPM_PULLUP_IN; // R7
        drv_d.pull_en = 1'b1; // R7
      end
      default: begin
        if (i_cfg.ddr) begin
          mode_d = i_cfg.opt ? GPM_PUSH_PULL : GPM_OPEN_DRAIN; // R1
          drv_d.out = i_cfg.opt & i_cfg.data; // R1
          drv_d.oe = i_cfg.opt | ~i_cfg.data; // R1
        end else if (i_cfg.opt) begin
          drv_d.irq_en = (PIN_CLASS != GPM_CLASS_STD); // R2
          drv_d.pull_en = (PIN_CLASS != GPM_CLASS_INT_NOPU); // R3
          mode_d = drv_d.pull_en ? GPM_PULLUP_IN : GPM_FLOAT_IN; // R1
        end
      end
    endcase
  end

  // input synchroniser; second stage feeds everything
  always_comb begin
    sync_d = sync1_q;
  end

  // registers
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      mode_q <= GPM_FLOAT_IN;
      drv_q <= '0;
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
    end else begin
      mode_q <= mode_d;
      drv_q <= drv_d;
      sync1_q <= i_pad_in;
      sync2_q <= sync_d;
    end
  end

  assign o_mode = mode_q;
  assign o_pad_out = drv_q.out;
  assign o_pad_oe = drv_q.oe;
  assign o_pull_en = drv_q.pull_en;
  assign o_irq_en = drv_q.irq_en;
  assign o_irq_in = sync2_q;
  assign o_in_sync = sync2_q;

  // a true open-drain pin never drives a high level
  a_tod_no_high: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // R4
    (mode_q == GPM_TRUE_OD) |-> !(o_pad_oe && o_pad_out))
    else $error("true open drain drives high");
  // push-pull output follows data, one cycle after config; antecedents sample reset
  // because the edge that releases reset still leaves the registers cleared
  a_pp_drive: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // R1
    (i_reset_n && PIN_CLASS <= GPM_CLASS_INT_NOPU && i_cfg.ddr && i_cfg.opt) |=> (o_pad_oe
    && o_pad_out == $past(i_cfg.data) && mode_q == GPM_PUSH_PULL))
    else $error("push-pull drive wrong");
  // open drain releases a high bit
  a_od_release: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // R1
    (i_reset_n && PIN_CLASS <= GPM_CLASS_INT_NOPU && i_cfg.ddr && !i_cfg.opt && i_cfg.data)
    |=> !o_pad_oe)
    else $error("open drain drove high");
  // pull-up interrupt input
  a_int_pullup: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // R2
    (i_reset_n && PIN_CLASS == GPM_CLASS_INT_PU && !i_cfg.ddr && i_cfg.opt)
    |=> (o_irq_en && o_pull_en && !o_pad_oe))
    else $error("pull-up interrupt input wrong");
  // floating interrupt input
  a_int_float: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // R3
    (i_reset_n && PIN_CLASS == GPM_CLASS_INT_NOPU && !i_cfg.ddr && i_cfg.opt)
    |=> (o_irq_en && !o_pull_en && mode_q == GPM_FLOAT_IN))
    else $error("floating interrupt input wrong");
  // input-only pull-up pin
  a_pu_only: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // R7
    (i_reset_n && PIN_CLASS == GPM_CLASS_PU_ONLY) |=> (o_pull_en && !o_pad_oe && !o_irq_en))
    else $error("pull-up only pin misbehaves");
  // synchroniser latency two cycles, counted from an edge taken out of reset
  a_sync_lat: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // R1
    i_reset_n |-> ##2 (o_in_sync == $past(i_pad_in, 2)))
    else $error("input sync latency wrong");
  // interrupt never enabled on standard pin
  a_std_noirq: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // R1
    (PIN_CLASS == GPM_CLASS_STD) |-> !o_irq_en)
    else $error("standard pin has interrupt");
endmodule

// ---- design/gpm_port.sv ----
// eight-pin port of mixed classes built from pin cells
`timescale 1ns/1ps
module gpm_port (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  // configuration per pin
  input wire gpm_pkg::gpm_cfg_t [7:0] i_cfg,
  // pads
  input wire logic [7:0] i_pad_in,
  output logic [7:0] o_pad_out,
  output logic [7:0] o_pad_oe,
  output logic [7:0] o_pull_en,
  // core side
  output logic [7:0] o_in_data,
  output logic [7:0] o_irq_in,
  output logic [7:0] o_irq_en
);
  import gpm_pkg::*;

  // ****************************************
  // pin class map: 7:6 true od, 5 pull-up only, 4 std,
  // 3 no-pull interrupt, 2:0 pull-up interrupt
  // ****************************************
  localparam logic [23:0] CLASS_MAP = {GPM_CLASS_TRUE_OD, GPM_CLASS_TRUE_OD,
    GPM_CLASS_PU_ONLY, GPM_CLASS_STD, GPM_CLASS_INT_NOPU,
    GPM_CLASS_INT_PU, GPM_CLASS_INT_PU, GPM_CLASS_INT_PU};

  // one cell per pin; cell outputs are flip-flops
  for (genvar g = 0; g < GPM_PINS; g++) begin : g_pin
    gpm_pin_cell #(.PIN_CLASS(CLASS_MAP[3*g +: 3])) u_cell (
      .i_ref_clk(i_ref_clk),
      .i_reset_n(i_reset_n),
      .i_cfg(i_cfg[g]),
      .i_pad_in(i_pad_in[g]),
      .o_pad_out(o_pad_out[g]),
      .o_pad_oe(o_pad_oe[g]),
      .o_pull_en(o_pull_en[g]),
      .o_irq_in(o_irq_in[g]),
      .o_irq_en(o_irq_en[g]),
      .o_in_sync(o_in_data[g]),
      .o_mode()
    );
  end
endmodule

// ---- verification/gpm_pad_model.sv ----
// board side of the pads: external drive, pulls and floating lines
`timescale 1ns/1ps
module gpm_pad_model (
  // clock
  input wire logic i_ref_clk,
  // drive from the port
  input wire logic [7:0] i_pad_out,
  input wire logic [7:0] i_pad_oe,
  input wire logic [7:0] i_pull_en,
  // board drive
  input wire logic [7:0] i_ext_en,
  input wire logic [7:0] i_ext_val,
  // resolved level
  output logic [7:0] o_pad_level
);
  logic flip_q = 1'b0;
  // a floating line wanders each cycle, odd pins opposite to even ones, so a lost pull-up cannot pass on every pin at once
  always @(posedge i_ref_clk) begin
    flip_q <= ~flip_q;
  end
  // the port's own drive wins, then the board, then the pull-up
  always_comb begin
    for (int g = 0; g < 8; g++) begin
      if (i_pad_oe[g]) o_pad_level[g] = i_pad_out[g];
      else if (i_ext_en[g]) o_pad_level[g] = i_ext_val[g];
      else if (i_pull_en[g]) o_pad_level[g] = 1'b1;
      else o_pad_level[g] = flip_q ^ g[0];
    end
  end
endmodule

// ---- verification/testbench.sv ----
// self-checking bench for the eight-pin mode port
`timescale 1ns/1ps
module testbench;
  import gpm_pkg::*;
  logic i_ref_clk = 1'b0;
  logic i_reset_n = 1'b0;
  gpm_cfg_t [7:0] cfg = '0;
  logic [7:0] ext_en = 8'h00;
  logic [7:0] ext_val = 8'h00;
  logic [7:0] pad_in, pad_out, pad_oe, pull_en, in_data, irq_in, irq_en;
  int errors = 0;
  int comparisons = 0;
  gpm_port i_dut (.i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n), .i_cfg(cfg),
    .i_pad_in(pad_in), .o_pad_out(pad_out), .o_pad_oe(pad_oe), .o_pull_en(pull_en),
    .o_in_data(in_data), .o_irq_in(irq_in), .o_irq_en(irq_en));
  gpm_pad_model i_pads (.i_ref_clk(i_ref_clk), .i_pad_out(pad_out), .i_pad_oe(pad_oe),
    .i_pull_en(pull_en), .i_ext_en(ext_en), .i_ext_val(ext_val), .o_pad_level(pad_in));
  // 8 ns period
  initial begin
    forever #4 i_ref_clk = ~i_ref_clk;
  end
  // expected drive per pin, c = {ddr,opt,data}; pins 7,6 sink only, 5 pulls only
  task automatic chk_drv(input logic [2:0] c);
    logic [3:0] e;
    for (int g = 0; g < 8; g++) begin
      if (g >= 6) e = {1'b0, c[2] & ~c[0], 2'b00};
      else if (g == 5) e = 4'h2;
      else if (c[2]) e = {c[1] & c[0], c[1] | ~c[0], 2'b00};
      else e = {2'b00, c[1] & (g != 3), c[1] & (g <= 3)};
      comparisons++;
      if ({pad_out[g], pad_oe[g], pull_en[g], irq_en[g]} !== e) begin
        errors++;
        $display("MISMATCH %0t pin %0d drive code %b", $time, g, c);
      end
    end
  endtask
  // synchronised input on both core outputs, masked pins are not judged
  task automatic chk_in(input logic [7:0] e, input logic [7:0] m);
    comparisons++;
    if (((in_data & m) !== (e & m)) || ((irq_in & m) !== (e & m))) begin
      errors++;
      $display("MISMATCH %0t input %h", $time, in_data);
    end
  endtask
  // every code on every class, one new code each cycle pair
  task automatic t_modes;
    for (int k = 0; k < 8; k++) begin
      @(posedge i_ref_clk);
      cfg <= {8{k[2:0]}};
      @(posedge i_ref_clk);
      #1 chk_drv(k[2:0]);
    end
  endtask
  // board levels, then pulls and sinking drains seen through the synchroniser
  task automatic t_input;
    @(posedge i_ref_clk);
    cfg <= '0;
    ext_en <= 8'hff;
    ext_val <= 8'ha5;
    repeat (4) @(posedge i_ref_clk);
    #1 chk_in(8'ha5, 8'hff);
    @(posedge i_ref_clk);
    // wake pins set up as pull-up interrupt inputs, then written again as a precaution
    cfg <= {{2{3'b100}}, {6{3'b010}}};
    ext_en <= 8'h00;
    @(posedge i_ref_clk);
    cfg <= {{2{3'b100}}, {6{3'b010}}};
    repeat (3) @(posedge i_ref_clk);
    #1 chk_in(8'h37, 8'hf7);
  endtask
  task automatic report_and_stop;
    if (errors == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge i_ref_clk);
    i_reset_n <= 1'b1;
    t_modes();
    t_input();
    report_and_stop();
  end
endmodule
